// ==== rtl/ncs_cfg.svh ====
`ifndef NCS_CFG_SVH
`define NCS_CFG_SVH
// Notes on behaviour
// - Five per-block bits show whether each block's stored code was fetched.
// - Five per-block bits show whether each detected error is repairable.
// - Five per-block bits give the pass or fail result of each check.
// - Five per-block bits show whether each computed code is valid.
// - One status bit gives direction of last operation: 0 write, 1 read.
// - Two-bit outcome: ok, bad address, partial block, skipped by jump.
// - The outcome field changes only when a calculation finishes.
// - One status bit reads 0 when idle and 1 when busy.
// - Six raw flags: abort, extra block, then data blocks 3 to 0.
// - Status is read-only except low five flags; writing 1 clears.
// - Two-bit extra size field selects 4, 8, 16 or 32 bytes.
// - Extra size and enable exist only when the extra option is built.
// - With extra enabled, a small block after the last 512 bytes is handled.
// - Abort raises the interrupt when the abort enable bit is set.
// - A correct fetched code raises the interrupt when pass enable is set.
// - Reserved upper bits of both registers carry no defined value.
// - Mode field: bypass, compute only, compute store and check; 11 reserved.

// ********************************
// Register offsets
// ********************************
`define NCS_OFS_STATUS   4'h0
`define NCS_OFS_CONFIG   4'h4

// ********************************
// Status field positions
// ********************************
`define NCS_ST_FETCH_HI  29
`define NCS_ST_FETCH_LO  25
`define NCS_ST_FIX_HI    24
`define NCS_ST_FIX_LO    20
`define NCS_ST_FAIL_HI   19
`define NCS_ST_FAIL_LO   15
`define NCS_ST_VALID_HI  14
`define NCS_ST_VALID_LO  10
`define NCS_ST_RNW       9
`define NCS_ST_LAST_HI   8
`define NCS_ST_LAST_LO   7
`define NCS_ST_BUSY      6
`define NCS_ST_FLAG_HI   5
`define NCS_ST_CLR_HI    4
`define NCS_FLAG_ABORT   5
`define NCS_FLAG_EXTRA   4

// ********************************
// Config field positions and values
// ********************************
`define NCS_CF_USED_HI   12
`define NCS_CF_MODE_HI   3
`define NCS_CF_MODE_LO   2
`define NCS_RST_STATUS   32'h0000_0000
`define NCS_RST_LAST     2'h0
`define NCS_RST_CFG      13'h0000
`define NCS_MODE_BYPASS  2'h0
`define NCS_MODE_CALC    2'h1
`define NCS_MODE_STORE   2'h2
`define NCS_XSZ_4        2'h0
`define NCS_XSZ_8        2'h1
`define NCS_XSZ_16       2'h2
`define NCS_BYTES_4      6'h04
`define NCS_BYTES_8      6'h08
`define NCS_BYTES_16     6'h10
`define NCS_BYTES_32     6'h20
`endif

// ==== rtl/ncs_pkg.sv ====
package ncs_pkg;
  // One result report from the correction engine, one bit per block
  typedef struct packed {
    logic [4:0] upd;
    logic [4:0] fetched;
    logic [4:0] can_fix;
    logic [4:0] fail;
    logic [4:0] valid;
  } ncs_res_type;

  typedef struct packed {
    logic [4:0] fetched;
    logic [4:0] can_fix;
    logic [4:0] fail;
    logic [4:0] valid;
  } ncs_flags_type;

  // Same order as config bits 12:0
  typedef struct packed {
    logic [1:0] xsize;
    logic       xen;
    logic       int_abort;
    logic       int_pass;
    logic [7:0] low;
  } ncs_cfg_type;

  typedef enum logic [1:0] {
    NCS_IDLE = 2'b01,
    NCS_BUSY = 2'b10
  } ncs_state_type;
endpackage

// ==== rtl/ncs_blk_flags.sv ====
`include "ncs_cfg.svh"
module ncs_blk_flags #(
  parameter bit EXTRA_OPT = 1'b1
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clr,
  input  wire logic                  xen,
  input  wire ncs_pkg::ncs_res_type  res,
  output ncs_pkg::ncs_flags_type     flags_ff
);
  ncs_pkg::ncs_flags_type nxt_flags;
  logic [4:0]             take;

  // Block 4 is the extra block and only reports when it is built and on
  assign take = {res.upd[4] & xen & EXTRA_OPT, res.upd[3:0]};

  always_comb begin
    nxt_flags = flags_ff;
    if (clr) begin
      nxt_flags = '0;
    end
    for (int i = 0; i < 5; i++) begin
      if (take[i]) begin
        nxt_flags.fetched[i] = res.fetched[i];
        nxt_flags.can_fix[i] = res.can_fix[i];
        nxt_flags.fail[i]    = res.fail[i];
        nxt_flags.valid[i]   = res.valid[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
endmodule

// ==== rtl/ncs_regs.sv ====
`include "ncs_cfg.svh"
module ncs_regs #(
  parameter bit EXTRA_OPT = 1'b1
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,

  // Register access port
  input  wire logic [3:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [31:0]           reg_wdata,
  output logic [31:0]                reg_rdata_ff,

  // Correction engine side
  input  wire logic                  eng_start,
  input  wire logic                  eng_rnw,
  input  wire logic                  eng_done,
  input  wire logic [1:0]            eng_last,
  input  wire logic                  eng_abort,
  input  wire logic [4:0]            eng_pass,
  input  wire ncs_pkg::ncs_res_type  eng_res,

  // Settings toward the engine, plus busy and interrupt outputs
  output ncs_pkg::ncs_cfg_type       cfg_ff,
  output logic                       mode_calc_ff,
  output logic                       mode_store_ff,
  output logic [5:0]                 extra_bytes_ff,
  output logic                       busy_ff,
  output logic                       irq_ff
);

  // ********************************
  // Declarations
  // ********************************
  ncs_pkg::ncs_state_type  state_ff;
  ncs_pkg::ncs_state_type  nxt_state;
  ncs_pkg::ncs_flags_type  blk_flags;
  ncs_pkg::ncs_cfg_type    nxt_cfg;
  logic                    rnw_ff;
  logic                    nxt_rnw;
  logic [1:0]              last_ff;
  logic [1:0]              nxt_last;
  logic [5:0]              raw_ff;
  logic [5:0]              nxt_raw;
  logic [5:0]              raw_set;
  logic [5:0]              raw_clr;
  logic                    sel_status;
  logic                    sel_config;
  logic                    wr_status;
  logic                    wr_config;
  logic                    start_ok;
  logic                    done_ok;
  logic                    nxt_busy;
  logic                    nxt_irq;
  logic                    nxt_calc;
  logic                    nxt_store;
  logic [5:0]              nxt_bytes;
  logic [1:0]              nxt_mode;
  logic [31:0]             status_word;
  logic [31:0]             config_word;
  logic [31:0]             read_word;
  logic [31:0]             nxt_rdata;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [5:0] xsize_bytes(input logic [1:0] code);
    logic [5:0] b;
    b = `NCS_BYTES_32;
    case (code)
      `NCS_XSZ_4:  b = `NCS_BYTES_4;
      `NCS_XSZ_8:  b = `NCS_BYTES_8;
      `NCS_XSZ_16: b = `NCS_BYTES_16;
      default:     b = `NCS_BYTES_32;
    endcase
    return b;
  endfunction

  // Mode field of a settings word
  function automatic logic [1:0] mode_of(input ncs_pkg::ncs_cfg_type c);
    return c.low[`NCS_CF_MODE_HI:`NCS_CF_MODE_LO];
  endfunction

  // ********************************
  // Address decode
  // ********************************
  assign sel_status = (reg_addr == `NCS_OFS_STATUS);
  assign sel_config = (reg_addr == `NCS_OFS_CONFIG);
  assign wr_status  = reg_wr & sel_status;
  assign wr_config  = reg_wr & sel_config;

  // ********************************
  // Activity tracking
  // ********************************
  // A start seen while busy is ignored so the captured direction stays
  // tied to the calculation that is actually running
  assign start_ok = eng_start & (state_ff == ncs_pkg::NCS_IDLE);
  assign done_ok  = eng_done & (state_ff == ncs_pkg::NCS_BUSY);

  always_comb begin
    nxt_state = state_ff;
    // A done and a start in one busy cycle: the done wins and the start is
    // dropped, so the engine must leave a cycle between them
    case (state_ff)
      ncs_pkg::NCS_IDLE: begin
        if (eng_start) begin
          nxt_state = ncs_pkg::NCS_BUSY;
        end
      end
      ncs_pkg::NCS_BUSY: begin
        if (eng_done) begin
          nxt_state = ncs_pkg::NCS_IDLE;
        end
      end
      default: begin
        nxt_state = ncs_pkg::NCS_IDLE;
      end
    endcase
  end

  // Busy comes from the next state so the status bit and the output toggle
  // on the same edge as the state itself
  assign nxt_busy = (nxt_state == ncs_pkg::NCS_BUSY);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ncs_pkg::NCS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // ********************************
  // Direction and outcome
  // ********************************
  assign nxt_rnw  = start_ok ? eng_rnw : rnw_ff;
  // Only an accepted done moves the outcome, so a stray done while idle
  // cannot overwrite a result that software has not read yet
  assign nxt_last = done_ok ? eng_last : last_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rnw_ff <= 1'b0;
    end else begin
      rnw_ff <= nxt_rnw;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      last_ff <= `NCS_RST_LAST;
    end else begin
      last_ff <= nxt_last;
    end
  end

  // ********************************
  // Per-block results
  // ********************************
  // Results of the previous calculation are wiped when a new one starts
  ncs_blk_flags #(
    .EXTRA_OPT (EXTRA_OPT)
  ) u_blk_flags (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clr       (start_ok),
    .xen       (cfg_ff.xen),
    .res       (eng_res),
    .flags_ff  (blk_flags)
  );

  // ********************************
  // Raw interrupt flags
  // ********************************
  // Extra block pass only counts when that block is built and enabled
  // Bit order: abort, extra block, then data blocks 3 down to 0
  assign raw_set = {eng_abort,
                    eng_pass[`NCS_FLAG_EXTRA] & cfg_ff.xen & EXTRA_OPT,
                    eng_pass[3:0]};

  // Only the low five flags take a write; abort has no write path, so it
  // is dropped when the next calculation starts instead
  assign raw_clr = {start_ok,
                    wr_status ? reg_wdata[`NCS_ST_CLR_HI:0] : 5'h00};

  // A set in the same cycle as its clear wins, so no event is lost.
  // The interrupt is built from this next value, so it drops on the same
  // edge as the clearing write rather than one cycle later
  assign nxt_raw = (raw_ff & ~raw_clr) | raw_set;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      raw_ff <= 6'h00;
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  // ********************************
  // Interrupt output
  // ********************************
  assign nxt_irq = (nxt_raw[`NCS_FLAG_ABORT] & cfg_ff.int_abort)
                 | ((|nxt_raw[`NCS_FLAG_EXTRA:0]) & cfg_ff.int_pass);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ********************************
  // Configuration register
  // ********************************
  // No busy interlock here: software is expected to poll busy first, and
  // a write while busy takes effect at once
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_config) begin
      nxt_cfg = ncs_pkg::ncs_cfg_type'(reg_wdata[`NCS_CF_USED_HI:0]);
    end
    if (!EXTRA_OPT) begin
      nxt_cfg.xsize = `NCS_XSZ_4;
      nxt_cfg.xen   = 1'b0;
    end
  end

  // Reserved mode 11 is treated as bypass
  assign nxt_mode  = mode_of(nxt_cfg);
  assign nxt_calc  = (nxt_mode == `NCS_MODE_CALC) | (nxt_mode == `NCS_MODE_STORE);
  assign nxt_store = (nxt_mode == `NCS_MODE_STORE);
  assign nxt_bytes = nxt_cfg.xen ? xsize_bytes(nxt_cfg.xsize) : 6'h00;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_ff <= ncs_pkg::ncs_cfg_type'(`NCS_RST_CFG);
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // The decoded copies are registered beside the settings, so the engine
  // never sees a mode that disagrees with the stored field
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_calc_ff  <= 1'b0;
      mode_store_ff <= 1'b0;
    end else begin
      mode_calc_ff  <= nxt_calc;
      mode_store_ff <= nxt_store;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      extra_bytes_ff <= 6'h00;
    end else begin
      extra_bytes_ff <= nxt_bytes;
    end
  end

  // ********************************
  // Read path
  // ********************************
  // A read in the same cycle as an event returns the value from before
  // that event; the event shows on the next read
  // Reserved bits are free to read as anything; zero is the cheapest
  always_comb begin
    status_word = `NCS_RST_STATUS;
    status_word[`NCS_ST_FETCH_HI:`NCS_ST_FETCH_LO] = blk_flags.fetched;
    status_word[`NCS_ST_FIX_HI:`NCS_ST_FIX_LO]     = blk_flags.can_fix;
    status_word[`NCS_ST_FAIL_HI:`NCS_ST_FAIL_LO]   = blk_flags.fail;
    status_word[`NCS_ST_VALID_HI:`NCS_ST_VALID_LO] = blk_flags.valid;
    status_word[`NCS_ST_RNW]                       = rnw_ff;
    status_word[`NCS_ST_LAST_HI:`NCS_ST_LAST_LO]   = last_ff;
    status_word[`NCS_ST_BUSY]                      = busy_ff;
    status_word[`NCS_ST_FLAG_HI:0]                 = raw_ff;
  end

  assign config_word = {19'h00000, cfg_ff};

  assign read_word = sel_status ? status_word :
                     sel_config ? config_word : 32'h0000_0000;

  // Read data are held until the next read so a slow reader sees them
  assign nxt_rdata = reg_rd ? read_word : reg_rdata_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule

// ==== testbench/ncs_regs_chk.sv ====
module ncs_regs_chk #(
  parameter bit EXTRA_OPT = 1'b1
) (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic [3:0]           reg_addr,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_wdata,
  input wire logic [31:0]          reg_rdata_ff,
  input wire logic                 eng_start,
  input wire logic                 eng_done,
  input wire logic                 eng_abort,
  input wire logic [4:0]           eng_pass,
  input wire ncs_pkg::ncs_cfg_type cfg_ff,
  input wire logic                 mode_calc_ff,
  input wire logic                 mode_store_ff,
  input wire logic [5:0]           extra_bytes_ff,
  input wire logic                 busy_ff,
  input wire logic                 irq_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ********************************
  // Steps
  // ********************************
  sequence s_start_idle;
    eng_start && !busy_ff;
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 4'h0;
  endsequence

  // ********************************
  // Properties
  // ********************************
  a_busy_start: assert property (s_start_idle |=> busy_ff)
    else $error("busy did not rise after start");
  a_busy_done: assert property (busy_ff && eng_done |=> !busy_ff)
    else $error("busy did not fall after done");
  a_busy_hold: assert property (!(busy_ff ? eng_done : eng_start) |=> $stable(busy_ff))
    else $error("busy changed without a cause");
  a_stat_busy: assert property (s_stat_rd |=> reg_rdata_ff[6] == $past(busy_ff)
    && reg_rdata_ff[31:30] == 2'h0) else $error("status busy bit wrong");
  a_cfg_read: assert property (reg_rd && reg_addr == 4'h4
    |=> reg_rdata_ff == {19'h0, $past(cfg_ff)}) else $error("config read wrong");
  a_unmapped_read: assert property (reg_rd && !(reg_addr inside {4'h0, 4'h4})
    |=> reg_rdata_ff == 32'h0) else $error("unmapped read not zero");
  a_cfg_write: assert property (reg_wr && reg_addr == 4'h4 |=>
    cfg_ff[9:0] == $past(reg_wdata[9:0]) && cfg_ff[12:10] ==
    (EXTRA_OPT ? $past(reg_wdata[12:10]) : 3'h0)) else $error("config write lost");
  a_extra_size: assert property ($stable(cfg_ff) |-> extra_bytes_ff ==
    (cfg_ff.xen ? 6'h04 << cfg_ff.xsize : 6'h00)) else $error("extra size wrong");
  a_mode_map: assert property ($stable(cfg_ff) |->
    mode_store_ff == (cfg_ff.low[3:2] == 2'h2) &&
    mode_calc_ff == (cfg_ff.low[3:2] inside {2'h1, 2'h2})) else $error("mode wrong");
  a_irq_abort: assert property (eng_abort && !eng_start && cfg_ff.int_abort
    && !reg_wr |=> irq_ff) else $error("abort gave no interrupt");
  a_irq_pass: assert property (eng_pass[0] && !eng_start && cfg_ff.int_pass
    && !reg_wr |=> irq_ff) else $error("pass gave no interrupt");
endmodule

bind ncs_regs ncs_regs_chk #(.EXTRA_OPT(EXTRA_OPT)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
  .eng_start(eng_start), .eng_done(eng_done), .eng_abort(eng_abort),
  .eng_pass(eng_pass), .cfg_ff(cfg_ff), .mode_calc_ff(mode_calc_ff),
  .mode_store_ff(mode_store_ff), .extra_bytes_ff(extra_bytes_ff),
  .busy_ff(busy_ff), .irq_ff(irq_ff)
);

// ==== testbench/ncs_eng_model.sv ====
module ncs_eng_model (
  input  wire logic            core_clk,
  output logic                 eng_start,
  output logic                 eng_rnw,
  output logic                 eng_done,
  output logic [1:0]           eng_last,
  output logic                 eng_abort,
  output logic [4:0]           eng_pass,
  output ncs_pkg::ncs_res_type eng_res
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {eng_start, eng_rnw, eng_done, eng_last, eng_abort, eng_pass, eng_res} = '0;
  end
  // Entered just after an edge; every event lasts exactly one cycle
  task automatic fire(input logic st, input logic rnw, input logic dn,
                      input logic [1:0] last, input logic ab, input logic [4:0] pass,
                      input ncs_pkg::ncs_res_type res);
    {eng_start, eng_rnw, eng_done, eng_last} = {st, rnw, dn, last};
    {eng_abort, eng_pass, eng_res} = {ab, pass, res};
    @(posedge core_clk) #1;
    {eng_start, eng_done, eng_abort, eng_pass, eng_res} = '0;
    // Qualifiers go stale after use: show the inverse, not a held copy
    eng_rnw = ~rnw;
    eng_last = ~last;
    // A quiet cycle follows, so two events in a row never share a time step
    @(posedge core_clk) #1;
  endtask
endmodule

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic [5:0]  xb;
    logic [1:0]  m;
  } ncs_row_type;
  logic                 core_clk, sys_rst, reg_wr, reg_rd, mode_calc_ff, mode_store_ff;
  logic                 eng_start, eng_rnw, eng_done, eng_abort, busy_ff, irq_ff;
  logic [3:0]           reg_addr;
  logic [31:0]          reg_wdata, reg_rdata_ff;
  logic [1:0]           eng_last;
  logic [4:0]           eng_pass;
  logic [5:0]           extra_bytes_ff;
  ncs_pkg::ncs_res_type eng_res;
  ncs_pkg::ncs_cfg_type cfg_ff;
  logic [31:0]          nox_rdata_ff;
  logic [5:0]           nox_bytes_ff;
  int                   err_count, check_count;
  // m is {calc, store}
  ncs_row_type rows [7] = '{
    '{4'h4, 32'h0000_1c04, 32'h0000_1c04, 6'h20, 2'h2},
    '{4'h4, 32'hffff_0808, 32'h0000_0808, 6'h00, 2'h3},
    '{4'h4, 32'h0000_040c, 32'h0000_040c, 6'h04, 2'h0},
    '{4'h4, 32'h0000_1400, 32'h0000_1400, 6'h10, 2'h0},
    '{4'h8, 32'hffff_ffff, 32'h0000_0000, 6'h10, 2'h0},
    '{4'h4, 32'h0000_0f00, 32'h0000_0f00, 6'h08, 2'h0},
    '{4'h0, 32'hffff_ffff, 32'h0000_0000, 6'h08, 2'h0}};

  ncs_regs #(.EXTRA_OPT(1'b1)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .eng_start(eng_start), .eng_rnw(eng_rnw), .eng_done(eng_done),
    .eng_last(eng_last), .eng_abort(eng_abort), .eng_pass(eng_pass),
    .eng_res(eng_res), .cfg_ff(cfg_ff), .mode_calc_ff(mode_calc_ff),
    .mode_store_ff(mode_store_ff), .extra_bytes_ff(extra_bytes_ff),
    .busy_ff(busy_ff), .irq_ff(irq_ff));
  ncs_eng_model eng (
    .core_clk(core_clk), .eng_start(eng_start), .eng_rnw(eng_rnw),
    .eng_done(eng_done), .eng_last(eng_last), .eng_abort(eng_abort),
    .eng_pass(eng_pass), .eng_res(eng_res));
  // Same stimulus into a build without the extra block option
  ncs_regs #(.EXTRA_OPT(1'b0)) dut_noext (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(nox_rdata_ff),
    .eng_start(eng_start), .eng_rnw(eng_rnw), .eng_done(eng_done),
    .eng_last(eng_last), .eng_abort(eng_abort), .eng_pass(eng_pass),
    .eng_res(eng_res), .cfg_ff(), .mode_calc_ff(), .mode_store_ff(),
    .extra_bytes_ff(nox_bytes_ff), .busy_ff(), .irq_ff());

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge core_clk) #1;
    reg_rd = 1'b0;
    cmp(reg_rdata_ff, exp);
  endtask
  // Bounded poll; running out counts as a mismatch
  task automatic wait_idle();
    int n;
    for (n = 0; n < 16 && busy_ff !== 1'b0; n++) @(posedge core_clk) #1;
    cmp(32'(busy_ff), 32'h0);
    if (n == 16) final_report();
  endtask

  // ********************************
  // Sequence
  // ********************************
  initial begin
    err_count = 0;
    check_count = 0;
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 38'h0};
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rd(4'h0, 32'h0);
    @(posedge core_clk) #1;
    rd(4'h4, 32'h0);
    cmp(32'(irq_ff), 32'h0);
    wait_idle();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
      cmp(nox_rdata_ff, rows[i].q & 32'hffff_e3ff);
      cmp(32'(nox_bytes_ff), 32'h0);
      cmp(32'(extra_bytes_ff), 32'(rows[i].xb));
      cmp(32'({mode_calc_ff, mode_store_ff}), 32'(rows[i].m));
    end
    eng.fire(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00, '0);
    cmp(32'(busy_ff), 32'h1);
    eng.fire(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 5'h11, {5'h03, 5'h01, 5'h02, 5'h02, 5'h01});
    @(posedge core_clk) #1;
    rd(4'h0, 32'h0221_0651);
    cmp(32'(irq_ff), 32'h1);
    eng.fire(1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 5'h00, '0);
    @(posedge core_clk) #1;
    rd(4'h0, 32'h0221_0711);
    // A second done while idle must leave the outcome alone
    eng.fire(1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 5'h00, '0);
    @(posedge core_clk) #1;
    rd(4'h0, 32'h0221_0711);
    wr(4'h0, 32'h0000_0001);
    rd(4'h0, 32'h0221_0710);
    cmp(32'(irq_ff), 32'h1);
    wr(4'h0, 32'h0000_0010);
    rd(4'h0, 32'h0221_0700);
    cmp(32'(irq_ff), 32'h0);
    eng.fire(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 5'h00, '0);
    @(posedge core_clk) #1;
    cmp(32'(irq_ff), 32'h1);
    wr(4'h0, 32'h0000_0020);
    rd(4'h0, 32'h0221_0720);
    wr(4'h4, 32'h0000_0d00);
    @(posedge core_clk) #1;
    cmp(32'(irq_ff), 32'h0);
    eng.fire(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 5'h00, '0);
    @(posedge core_clk) #1;
    rd(4'h0, 32'h0000_0140);
    // First start lands while busy and must be ignored
    for (int k = 0; k < 4; k++) begin
      eng.fire(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00, '0);
      eng.fire(1'b0, 1'b0, 1'b1, k[1:0], 1'b0, 5'h00, '0);
      @(posedge core_clk) #1;
      rd(4'h0, {22'h0, k != 0, k[1:0], 7'h0});
    end
    // Reset while idle after the last done, with settings and outcome non-zero, must clear all
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    cmp(32'({busy_ff, irq_ff}), 32'h0);
    cmp(32'(extra_bytes_ff), 32'h0);
    cmp(32'(cfg_ff), 32'h0);
    rd(4'h0, 32'h0);
    @(posedge core_clk) #1;
    rd(4'h4, 32'h0);
    final_report();
  end
endmodule
